// File: gdsp_serial_cfg.sv
// Purpose: host and auxiliary asynchronous serial ports with settings reload
// Assumes: battery-backed and serial non-volatile stores sit outside, same clock
// Notes:   new settings take effect only after the next reset or master reset
`default_nettype none
`timescale 1ns/1ps

module gdsp_serial_cfg
    import gdsp_pkg::*;
#(
    parameter logic [15:0] P_DEF_DIV = DIV_DEF
) (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_b,
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    input  wire logic                i_wb_we,
    input  wire logic [7:0]          i_wb_adr,
    input  wire logic [3:0]          i_wb_sel,
    input  wire logic [31:0]         i_wb_dat,
    output logic                     o_wb_ack,
    output logic      [31:0]         o_wb_dat,
    input  wire logic                i_mrst_b,
    input  wire logic                i_host_rx_line,
    output logic                     o_host_tx_line,
    input  wire logic                i_aux_rx_line,
    output logic                     o_aux_tx_line,
    output logic                     o_host_nmea,
    input  wire logic [2*CFG_W-1:0]  i_sram_cfg,
    input  wire logic [7:0]          i_sram_sum,
    input  wire logic [2*CFG_W-1:0]  i_eeprom_cfg,
    input  wire logic [7:0]          i_eeprom_sum,
    output logic                     o_nv_we,
    output logic      [2*CFG_W-1:0]  o_nv_cfg,
    output logic      [7:0]          o_nv_sum
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        gdsp_state_t                     st;
        logic [1:0]                      src;
        logic [NCH-1:0][CFG_W-1:0]       act;
        logic [NCH-1:0][CFG_W-1:0]       pend;
        logic                            nv_we;
        logic [NCH-1:0][CFG_W-1:0]       nv_cfg;
        logic [7:0]                      nv_sum;
        logic [1:0]                      mr_sync;
        logic [NCH-1:0][1:0]             rx_sync;
        logic [NCH-1:0]                  rx_busy;
        logic [NCH-1:0][15:0]            rx_cnt;
        logic [NCH-1:0][3:0]             rx_bit;
        logic [NCH-1:0][7:0]             rx_sh;
        logic [NCH-1:0][7:0]             rx_data;
        logic [NCH-1:0]                  rx_valid;
        logic [NCH-1:0]                  rx_ovr;
        logic [NCH-1:0]                  rx_ferr;
        logic                            tx_busy;
        logic [15:0]                     tx_cnt;
        logic [3:0]                      tx_bit;
        logic [8:0]                      tx_sh;
        logic                            tx_line;
        logic                            wb_ack;
        logic [31:0]                     wb_dat;
    } gdsp_st_t;

    gdsp_st_t    st_ff;
    gdsp_st_t    nxt_st;

    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic        fifo_push;
    logic        fifo_pop;
    logic        wb_req;
    logic        wb_stall;

    function automatic logic [7:0] gdsp_cfg_sum(input logic [NCH-1:0][CFG_W-1:0] cfg);
        logic [8*SUM_BYTES-1:0] v;
        logic [7:0]             s;
        v = {{SUM_PAD{1'b0}}, cfg};
        s = 8'h00;
        for (int i = 0; i < SUM_BYTES; i++) begin
            s = s + v[i*8 +: 8];
        end
        return s;
    endfunction

    function automatic logic [31:0] gdsp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // bus handshake and transmit buffer
    // ****************************************
    assign wb_req    = i_wb_cyc && i_wb_stb && !st_ff.wb_ack;
    // a full buffer holds off the ack until a slot frees
    assign wb_stall  = i_wb_we && (i_wb_adr == REG_TX_DATA) && !fifo_in_ready;
    assign fifo_push = wb_req && i_wb_we && (i_wb_adr == REG_TX_DATA) && i_wb_sel[0] && fifo_in_ready;
    assign fifo_pop  = (st_ff.st == ST_RUN) && !st_ff.tx_busy && fifo_out_valid;

    gdsp_fifo #(
        .W (DATA_BITS),
        .D (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_wb_dat[7:0]),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] rd;
        logic [31:0] wv;
        logic [15:0] div;
        nxt_st       = st_ff;
        rd           = 32'h0000_0000;
        wv           = 32'h0000_0000;
        div          = 16'h0000;
        nxt_st.nv_we = 1'b0;
        nxt_st.wb_ack = 1'b0;
        nxt_st.mr_sync = {st_ff.mr_sync[0], i_mrst_b};
        nxt_st.rx_sync[CH_HOST] = {st_ff.rx_sync[CH_HOST][0], i_host_rx_line};
        nxt_st.rx_sync[CH_AUX]  = {st_ff.rx_sync[CH_AUX][0], i_aux_rx_line};

        // reload sequencing
        case (st_ff.st)
            ST_LOAD: begin
                if (!st_ff.mr_sync[1]) begin
                    nxt_st.st = ST_HALT;
                end else if (gdsp_cfg_sum(i_sram_cfg) == i_sram_sum) begin
                    nxt_st.act = i_sram_cfg;
                    nxt_st.src = SRC_SRAM;
                    nxt_st.st  = ST_RUN;
                end else if (gdsp_cfg_sum(i_eeprom_cfg) == i_eeprom_sum) begin
                    nxt_st.act = i_eeprom_cfg;
                    nxt_st.src = SRC_EEPROM;
                    nxt_st.st  = ST_RUN;
                end else begin
                    nxt_st.act[CH_HOST] = {FMT_BINARY, P_DEF_DIV};
                    nxt_st.act[CH_AUX]  = {FMT_BINARY, P_DEF_DIV};
                    nxt_st.src          = SRC_ROM;
                    nxt_st.st           = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!st_ff.mr_sync[1]) begin
                    nxt_st.st = ST_HALT;
                end
            end
            ST_HALT: begin
                if (st_ff.mr_sync[1]) begin
                    nxt_st.st = ST_LOAD;
                end
            end
            default: begin
                nxt_st.st = ST_LOAD;
            end
        endcase

        for (int c = 0; c < NCH; c++) begin
            div = st_ff.act[c][FMT_BIT-1:0];
            if (st_ff.st != ST_RUN) begin
                nxt_st.rx_busy[c] = 1'b0;
            end else if (!st_ff.rx_busy[c]) begin
                if (st_ff.rx_sync[c][1] == LINE_START) begin
                    nxt_st.rx_busy[c] = 1'b1;
                    nxt_st.rx_cnt[c]  = div >> 1;
                    nxt_st.rx_bit[c]  = BIT_START;
                end
            end else if (st_ff.rx_cnt[c] != 16'h0000) begin
                nxt_st.rx_cnt[c] = st_ff.rx_cnt[c] - 16'h0001;
            end else begin
                nxt_st.rx_cnt[c] = div - 16'h0001;
                nxt_st.rx_bit[c] = st_ff.rx_bit[c] + 4'h1;
                if (st_ff.rx_bit[c] == BIT_START) begin
                    // glitch rejection
                    if (st_ff.rx_sync[c][1] != LINE_START) begin
                        nxt_st.rx_busy[c] = 1'b0;
                    end
                end else if (st_ff.rx_bit[c] != BIT_STOP) begin
                    nxt_st.rx_sh[c] = {st_ff.rx_sync[c][1], st_ff.rx_sh[c][7:1]};
                end else begin
                    nxt_st.rx_busy[c] = 1'b0;
                    if (st_ff.rx_sync[c][1] == LINE_IDLE) begin
                        nxt_st.rx_data[c] = st_ff.rx_sh[c];
                        if (st_ff.rx_valid[c]) begin
                            nxt_st.rx_ovr[c] = 1'b1;
                        end
                    end else begin
                        nxt_st.rx_ferr[c] = 1'b1;
                    end
                end
            end
        end

        div = st_ff.act[CH_HOST][FMT_BIT-1:0];
        if (st_ff.st != ST_RUN) begin
            nxt_st.tx_busy = 1'b0;
            nxt_st.tx_line = LINE_IDLE;
        end else if (fifo_pop) begin
            nxt_st.tx_busy = 1'b1;
            nxt_st.tx_sh   = {LINE_IDLE, fifo_out_data};
            nxt_st.tx_bit  = BIT_START;
            nxt_st.tx_cnt  = div - 16'h0001;
            nxt_st.tx_line = LINE_START;
        end else if (st_ff.tx_busy) begin
            if (st_ff.tx_cnt != 16'h0000) begin
                nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
            end else if (st_ff.tx_bit == BIT_STOP) begin
                nxt_st.tx_busy = 1'b0;
                nxt_st.tx_line = LINE_IDLE;
            end else begin
                nxt_st.tx_cnt  = div - 16'h0001;
                nxt_st.tx_bit  = st_ff.tx_bit + 4'h1;
                nxt_st.tx_line = st_ff.tx_sh[0];
                nxt_st.tx_sh   = {LINE_IDLE, st_ff.tx_sh[8:1]};
            end
        end

        // ****************************************
        // register access
        // ****************************************
        case (i_wb_adr)
            REG_CTRL:     rd = {26'h0, st_ff.src, 2'h0, st_ff.st};
            REG_HOST_NEW: rd = {15'h0, st_ff.pend[CH_HOST]};
            REG_AUX_NEW:  rd = {15'h0, st_ff.pend[CH_AUX]};
            REG_HOST_ACT: rd = {15'h0, st_ff.act[CH_HOST]};
            REG_AUX_ACT:  rd = {15'h0, st_ff.act[CH_AUX]};
            REG_HOST_RXD: rd = {23'h0, st_ff.rx_valid[CH_HOST], st_ff.rx_data[CH_HOST]};
            REG_AUX_RXD:  rd = {23'h0, st_ff.rx_valid[CH_AUX], st_ff.rx_data[CH_AUX]};
            REG_STATUS:   rd = {24'h0, st_ff.rx_ferr, st_ff.rx_ovr, st_ff.rx_valid,
                                st_ff.tx_busy, !fifo_in_ready};
            default:      rd = 32'h0000_0000;
        endcase

        if (wb_req && !wb_stall) begin
            nxt_st.wb_ack = 1'b1;
            nxt_st.wb_dat = i_wb_we ? 32'h0000_0000 : rd;
            if (i_wb_we) begin
                case (i_wb_adr)
                    REG_CTRL: begin
                        if (i_wb_sel[0] && i_wb_dat[CTRL_COMMIT]) begin
                            nxt_st.nv_we  = 1'b1;
                            nxt_st.nv_cfg = st_ff.pend;
                            nxt_st.nv_sum = gdsp_cfg_sum(st_ff.pend);
                        end
                    end
                    REG_HOST_NEW: begin
                        wv = gdsp_merge({15'h0, st_ff.pend[CH_HOST]}, i_wb_dat, i_wb_sel);
                        nxt_st.pend[CH_HOST] = wv[CFG_W-1:0];
                    end
                    REG_AUX_NEW: begin
                        wv = gdsp_merge({15'h0, st_ff.pend[CH_AUX]}, i_wb_dat, i_wb_sel);
                        nxt_st.pend[CH_AUX] = wv[CFG_W-1:0];
                    end
                    REG_STATUS: begin
                        if (i_wb_sel[0]) begin
                            nxt_st.rx_ovr  = st_ff.rx_ovr & ~i_wb_dat[ST_OVR_LO +: NCH];
                            nxt_st.rx_ferr = st_ff.rx_ferr & ~i_wb_dat[ST_FERR_LO +: NCH];
                        end
                    end
                    default: begin
                        wv = 32'h0000_0000;
                    end
                endcase
            end else if (i_wb_adr == REG_HOST_RXD) begin
                nxt_st.rx_valid[CH_HOST] = 1'b0;
            end else if (i_wb_adr == REG_AUX_RXD) begin
                nxt_st.rx_valid[CH_AUX] = 1'b0;
            end
        end

        // new events win over a same-cycle clear
        for (int c = 0; c < NCH; c++) begin
            if (st_ff.rx_busy[c] && st_ff.rx_cnt[c] == 16'h0000 && st_ff.rx_bit[c] == BIT_STOP) begin
                if (st_ff.rx_sync[c][1] == LINE_IDLE) begin
                    nxt_st.rx_valid[c] = 1'b1;
                    nxt_st.rx_ovr[c]   = nxt_st.rx_ovr[c] | st_ff.rx_valid[c];
                end else begin
                    nxt_st.rx_ferr[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff         <= '0;
            st_ff.st      <= ST_LOAD;
            st_ff.act     <= {FMT_BINARY, P_DEF_DIV, FMT_BINARY, P_DEF_DIV};
            st_ff.pend    <= {FMT_BINARY, P_DEF_DIV, FMT_BINARY, P_DEF_DIV};
            st_ff.rx_sync <= '1;
            st_ff.tx_line <= LINE_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_wb_ack       = st_ff.wb_ack;
    assign o_wb_dat       = st_ff.wb_dat;
    assign o_host_tx_line = st_ff.tx_line;
    // receive-only port, transmit line parked high
    assign o_aux_tx_line  = LINE_IDLE;
    assign o_host_nmea    = st_ff.act[CH_HOST][FMT_BIT];
    assign o_nv_we        = st_ff.nv_we;
    assign o_nv_cfg       = st_ff.nv_cfg;
    assign o_nv_sum       = st_ff.nv_sum;

endmodule // gdsp_serial_cfg

`default_nettype wire

// File: gdsp_pkg.sv
// Purpose: shared constants and types of the dual serial port block
// Assumes: one 125 MHz clock, 32-bit classic Wishbone register access
// Notes:   configuration word per port is {format, bit period in clocks}
`default_nettype none

package gdsp_pkg;

    // ****************************************
    // clock and line timing
    // ****************************************
    localparam int          CLK_HZ      = 125_000_000;
    localparam int          BAUD_DEF    = 9600;
    localparam logic [15:0] DIV_DEF     = 16'((CLK_HZ + BAUD_DEF / 2) / BAUD_DEF);
    localparam int          DATA_BITS   = 8;
    localparam logic [3:0]  BIT_STOP    = 4'h9;
    localparam logic [3:0]  BIT_START   = 4'h0;
    localparam logic        LINE_IDLE   = 1'b1;
    localparam logic        LINE_START  = 1'b0;

    // ****************************************
    // configuration words
    // ****************************************
    localparam int          NCH         = 2;
    localparam int          CH_HOST     = 0;
    localparam int          CH_AUX      = 1;
    localparam int          CFG_W       = 17;
    localparam int          FMT_BIT     = 16;
    localparam logic        FMT_BINARY  = 1'b0;
    localparam logic        FMT_NMEA    = 1'b1;
    localparam logic [16:0] CFG_ROM     = {FMT_BINARY, DIV_DEF};
    localparam int          SUM_BYTES   = 5;
    localparam int          SUM_PAD     = 6;

    // load source codes
    localparam logic [1:0]  SRC_ROM     = 2'h0;
    localparam logic [1:0]  SRC_SRAM    = 2'h1;
    localparam logic [1:0]  SRC_EEPROM  = 2'h2;

    localparam int          FIFO_DEPTH  = 8;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_HOST_NEW = 8'h04;
    localparam logic [7:0]  REG_AUX_NEW  = 8'h08;
    localparam logic [7:0]  REG_HOST_ACT = 8'h0c;
    localparam logic [7:0]  REG_AUX_ACT  = 8'h10;
    localparam logic [7:0]  REG_TX_DATA  = 8'h14;
    localparam logic [7:0]  REG_HOST_RXD = 8'h18;
    localparam logic [7:0]  REG_AUX_RXD  = 8'h1c;
    localparam logic [7:0]  REG_STATUS   = 8'h20;

    // field positions
    localparam int          CTRL_COMMIT  = 0;
    localparam int          CTRL_SRC_LO  = 4;
    localparam int          RXD_VALID    = 8;
    localparam int          ST_TX_FULL   = 0;
    localparam int          ST_TX_BUSY   = 1;
    localparam int          ST_RXV_LO    = 2;
    localparam int          ST_OVR_LO    = 4;
    localparam int          ST_FERR_LO   = 6;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN  = 2'b01,
        ST_HALT = 2'b10
    } gdsp_state_t;

endpackage : gdsp_pkg

`default_nettype wire

// File: gdsp_fifo.sv
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   data output comes straight from the storage flops
`default_nettype none
`timescale 1ns/1ps

module gdsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } gdsp_fifo_st_t;

    gdsp_fifo_st_t st_ff;
    gdsp_fifo_st_t nxt_st;
    logic          full;
    logic          empty;

    assign empty       = (st_ff.wp == st_ff.rp);
    assign full        = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = st_ff.mem[st_ff.rp[AW-1:0]];

    always_comb begin
        nxt_st = st_ff;
        if (i_in_valid && !full) begin
            nxt_st.mem[st_ff.wp[AW-1:0]] = i_in_data;
            nxt_st.wp                    = st_ff.wp + 1'b1;
        end
        if (i_out_ready && !empty) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // gdsp_fifo

`default_nettype wire

// File: gdsp_serial_cfg_props.sv
// Purpose: bus, store-write and line checks of the serial port block
// Assumes: one clock domain, watches top ports only
// Notes:   bound from the testbench top file
`default_nettype none
`timescale 1ns/1ps
module gdsp_serial_cfg_props
    import gdsp_pkg::*;
(
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [7:0]         i_wb_adr,
    input  wire logic               o_wb_ack,
    input  wire logic               i_mrst_b,
    input  wire logic               o_host_tx_line,
    input  wire logic               o_aux_tx_line,
    input  wire logic               o_host_nmea,
    input  wire logic               o_nv_we,
    input  wire logic [2*CFG_W-1:0] o_nv_cfg
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    logic [3:0] since_ff;
    logic [3:0] nxt_since;
    logic       ctrl_wr;
    assign ctrl_wr = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr == REG_CTRL;
    // cycles since master reset was last high-going
    always_comb nxt_since = !i_mrst_b ? 4'h0 : (since_ff == 4'hf ? since_ff : since_ff + 4'h1);
    always_ff @(posedge i_ref_clk or negedge i_rst_b) if (!i_rst_b) since_ff <= 4'h0; else since_ff <= nxt_since;
    sequence s_mrst_held;
        !i_mrst_b [*6];
    endsequence
    sequence s_rd_req;
        i_wb_cyc && i_wb_stb && !i_wb_we;
    endsequence
    a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    a_read_answer: assert property (s_rd_req |-> ##[0:2] o_wb_ack) else $error("read not answered");
    a_aux_line_idle: assert property (o_aux_tx_line) else $error("aux output not high");
    a_nv_we_pulse: assert property (o_nv_we |=> !o_nv_we) else $error("store write not a pulse");
    a_nv_we_cause: assert property (o_nv_we |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("store write without commit");
    a_nv_cfg_hold: assert property ($changed(o_nv_cfg) |-> o_nv_we || $past(o_nv_we) || $past(ctrl_wr))
        else $error("store data moved without commit");
    a_nmea_hold: assert property ($changed(o_host_nmea) |-> since_ff < 4'hc)
        else $error("format changed outside reload");
    a_halt_line_idle: assert property (s_mrst_held |-> o_host_tx_line)
        else $error("host line not idle in master reset");
endmodule // gdsp_serial_cfg_props
`default_nettype wire

// File: gdsp_far_end.sv
// Purpose: application processor and correction source on the serial lines
// Assumes: bit period set by the bench in div
// Notes:   collects host characters as {stop, data}
`default_nettype none
`timescale 1ns/1ps
module gdsp_far_end (
    input  wire logic i_ref_clk,
    input  wire logic i_tx_line,
    output logic      o_host_rx_line,
    output logic      o_aux_rx_line
);
    int         div = 16;
    logic [8:0] got[$];
    initial begin
        o_host_rx_line = 1'b1;
        o_aux_rx_line = 1'b1;
    end
    task automatic send(input logic aux, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_ref_clk);
            if (aux) o_aux_rx_line <= f[i];
            else o_host_rx_line <= f[i];
            repeat (div - 1) @(posedge i_ref_clk);
        end
    endtask
    always begin
        logic [8:0] b;
        @(negedge i_tx_line);
        repeat (div / 2) @(posedge i_ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (div) @(posedge i_ref_clk);
            b[i] = i_tx_line;
        end
        got.push_back(b);
    end
endmodule // gdsp_far_end
`default_nettype wire

// File: tb_gdsp_serial_cfg.sv
// Purpose: self-checking bench of the dual serial port block
// Assumes: Wishbone classic master, fixed-seed stimulus
// Notes:   short ROM divisor for speed
`default_nettype none
`timescale 1ns/1ps
module tb_gdsp_serial_cfg import gdsp_pkg::*;;
    logic        ref_clk, rst_b, cyc, stb, we, ack, mrst_b, hrx, arx, htx, atx, nmea, nv_we;
    logic [7:0]  adr, sram_sum, ee_sum, nv_sum, rnd;
    logic [31:0] dat_w, dat_r;
    logic [33:0] sram_cfg, ee_cfg, nv_cfg;
    int          error_cnt, n_checks, cycles;
    gdsp_serial_cfg #(.P_DEF_DIV(16'h0010)) dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat_w), .o_wb_ack(ack),
        .o_wb_dat(dat_r), .i_mrst_b(mrst_b), .i_host_rx_line(hrx), .o_host_tx_line(htx),
        .i_aux_rx_line(arx), .o_aux_tx_line(atx), .o_host_nmea(nmea), .i_sram_cfg(sram_cfg),
        .i_sram_sum(sram_sum), .i_eeprom_cfg(ee_cfg), .i_eeprom_sum(ee_sum), .o_nv_we(nv_we),
        .o_nv_cfg(nv_cfg), .o_nv_sum(nv_sum));
    gdsp_far_end far (.i_ref_clk(ref_clk), .i_tx_line(htx), .o_host_rx_line(hrx), .o_aux_rx_line(arx));
    always #4 ref_clk = ~ref_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] ck(input logic [33:0] c);
        logic [39:0] v;
        v = {6'h00, c};
        return v[7:0] + v[15:8] + v[23:16] + v[31:24] + v[39:32];
    endfunction
    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [41:0] g, input logic [41:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic mreset();
        mrst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        mrst_b <= 1'b1;
        repeat (10) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        logic [31:0] q;
        logic [16:0] hc, ac, ec;
        logic [7:0]  b[9];
        {ref_clk, rst_b, cyc, stb, we, adr, dat_w, sram_cfg, ee_cfg} = '0;
        {mrst_b, sram_sum, ee_sum, rnd} = {1'b1, 8'h01, 8'h01, 8'h59};
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wb(0, REG_HOST_ACT, 0, q); chk(q, 42'h10);
        wb(0, REG_AUX_ACT, 0, q); chk(q, 42'h10);
        wb(0, 8'h24, 0, q); chk(q, 42'h0);
        chk(htx, 42'h1);
        rnd = lfsr(rnd);
        hc = {1'b1, 16'(8 + rnd[2:0])};
        ac = {1'b0, 16'(8 + rnd[5:3])};
        wb(1, REG_HOST_NEW, 32'(hc), q);
        wb(1, REG_AUX_NEW, 32'(ac), q);
        wb(1, REG_CTRL, 32'h1, q);
        repeat (4) @(posedge ref_clk);
        chk({nv_sum, nv_cfg}, {ck({ac, hc}), ac, hc});
        wb(0, REG_HOST_ACT, 0, q); chk(q, 42'h10);
        sram_cfg <= {ac, hc};
        sram_sum <= ck({ac, hc});
        mreset();
        wb(0, REG_HOST_ACT, 0, q); chk(q, 42'(hc));
        wb(0, REG_AUX_ACT, 0, q); chk(q, 42'(ac));
        wb(0, REG_CTRL, 0, q); chk(q[5:0], {2'h1, 4'h1});
        chk(nmea, 42'h1);
        ec = {1'b0, 16'(8 + rnd[7:6])};
        ee_cfg <= {ec, ec};
        ee_sum <= ck({ec, ec});
        sram_sum <= ~ck({ac, hc});
        mreset();
        wb(0, REG_HOST_ACT, 0, q); chk(q, 42'(ec));
        chk(nmea, 42'h0);
        far.div = int'(ec[15:0]);
        for (int i = 0; i < 9; i++) begin
            rnd = lfsr(rnd);
            b[i] = rnd;
            wb(1, REG_TX_DATA, 32'(rnd), q);
        end
        for (int n = 0; n < 3000 && far.got.size() < 9; n++) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) chk(far.got.pop_front(), {1'b1, b[i]});
        for (int p = 0; p < 2; p++) begin
            rnd = lfsr(rnd);
            far.send(p[0], rnd);
            repeat (far.div) @(posedge ref_clk);
            wb(0, p[0] ? REG_AUX_RXD : REG_HOST_RXD, 0, q); chk(q, {1'b1, rnd});
        end
        rnd = lfsr(rnd);
        far.send(0, rnd);
        far.send(0, ~rnd);
        repeat (far.div) @(posedge ref_clk);
        wb(0, REG_STATUS, 0, q); chk(q, 42'h14);
        wb(1, REG_STATUS, 32'hf0, q);
        wb(0, REG_HOST_RXD, 0, q); chk(q, {1'b1, ~rnd});
        wb(0, REG_STATUS, 0, q); chk(q, 42'h0);
        conclude();
    end
endmodule // tb_gdsp_serial_cfg
bind gdsp_serial_cfg gdsp_serial_cfg_props u_props (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack),
    .i_mrst_b(i_mrst_b), .o_host_tx_line(o_host_tx_line), .o_aux_tx_line(o_aux_tx_line),
    .o_host_nmea(o_host_nmea), .o_nv_we(o_nv_we), .o_nv_cfg(o_nv_cfg));
`default_nettype wire
